//--- hdl/lso_core.sv
`timescale 1ns/10ps
module lso_core import lso_pkg::*; #(
  parameter int NREG = 128,
  parameter int RW = 7,
  parameter int DEPTH = 256,
  parameter int IW = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_op_valid,
  input wire lso_op_t i_op_kind,
  input wire logic [RW-1:0] i_op_reg,
  input wire logic i_op_cls,
  input wire logic [SZ_W-1:0] i_op_size,
  input wire logic [IW+OFS_W-1:0] i_op_addr,
  input wire logic [DW-1:0] i_op_data,
  input wire logic i_op_fault,
  output logic o_op_ready,
  output logic o_use_valid,
  output logic [DW-1:0] o_use_data,
  output logic o_use_flag,
  output logic o_fault,
  output logic o_redirect
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic v;
    logic [RW-1:0] rg;
    logic [DW-1:0] data;
    logic flag;
  } lso_ld_t;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [NREG-1:0][DW-1:0] rf;
    logic [NREG-1:0] deferred_fault_flag;
    logic [NREG-1:0] busy;
    logic st_v;
    logic [IW-1:0] st_idx;
    logic [NBYTE-1:0] st_be;
    logic [DW-1:0] st_data;
    lso_ld_t [LD_STAGES-1:0] ld;
    logic use_v;
    logic [DW-1:0] use_data;
    logic use_flag;
    logic fault;
    logic redir;
  } lso_st_t;

  lso_st_t s;
  lso_st_t next_s;

  logic [IW-1:0] idx;
  logic [OFS_W-1:0] ofs;
  logic [NBYTE-1:0] be;
  logic [DW-1:0] merged;
  logic [DW-1:0] ld_val;
  logic hit;
  logic is_load;
  logic stall;
  logic accept;

  assign idx = i_op_addr[IW+OFS_W-1:OFS_W];
  assign ofs = i_op_addr[OFS_W-1:0];
  assign be = lso_be(i_op_size, ofs);

  // ----------------------------------------------------------------
  // load data: the store still waiting to commit wins per byte
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NBYTE; b++)
  begin : g_fwd
    assign merged[b*8 +: 8] = (s.st_v && (s.st_idx == idx) && s.st_be[b])
                              ? s.st_data[b*8 +: 8]
                              : s.mem[idx][b*8 +: 8];
  end

  // loads are zero extended; aligned accesses only, bytes of a misaligned one past the word end read as zero
  assign ld_val = (merged >> {ofs, 3'h0}) & lso_bits(lso_be(i_op_size, '0));

  // ----------------------------------------------------------------
  // advanced load table
  // ----------------------------------------------------------------
  lso_alt #(
    .NREG(NREG),
    .RW(RW),
    .IW(IW)
  ) u_alt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_alloc(accept && (i_op_kind == OP_ADV_LOAD)),
    .i_alloc_reg(i_op_reg),
    .i_alloc_idx(idx),
    .i_alloc_be(be),
    .i_alloc_cls(i_op_cls),
    .i_alloc_size(i_op_size),
    .i_inval(accept && (i_op_kind == OP_STORE)),
    .i_inval_idx(idx),
    .i_inval_be(be),
    .i_look_reg(i_op_reg),
    .i_look_cls(i_op_cls),
    .o_hit(hit)
  );

  // ----------------------------------------------------------------
  // issue control
  // ----------------------------------------------------------------
  always_comb
  begin
    is_load = 1'b0;
    stall = 1'b0;
    case (i_op_kind)
      OP_LOAD, OP_SPEC_LOAD, OP_ADV_LOAD:
      begin
        is_load = 1'b1;
        stall = s.busy[i_op_reg];
      end
      OP_CHK_LOAD:
      begin
        is_load = !hit;
        stall = s.busy[i_op_reg];
      end
      OP_CHK_ADV, OP_CHK_SPEC, OP_USE, OP_WRITE:
      begin
        stall = s.busy[i_op_reg];
      end
      default:
      begin
        stall = 1'b0;
      end
    endcase
  end

  assign o_op_ready = !stall;
  assign accept = i_op_valid && !stall;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.use_v = 1'b0;
    next_s.fault = 1'b0;
    next_s.redir = 1'b0;
    // stores commit one cycle late, in issue order, so the last one wins
    next_s.st_v = 1'b0;
    if (s.st_v)
    begin
      next_s.mem[s.st_idx] = (s.mem[s.st_idx] & ~lso_bits(s.st_be))
                             | (s.st_data & lso_bits(s.st_be));
    end
    // load writeback clears the scoreboard for the consumer
    if (s.ld[LD_STAGES-1].v)
    begin
      next_s.rf[s.ld[LD_STAGES-1].rg] = s.ld[LD_STAGES-1].data;
      next_s.deferred_fault_flag[s.ld[LD_STAGES-1].rg] = s.ld[LD_STAGES-1].flag;
      next_s.busy[s.ld[LD_STAGES-1].rg] = 1'b0;
    end
    for (int k = LD_STAGES - 1; k > 0; k--)
    begin
      next_s.ld[k] = s.ld[k-1];
    end
    next_s.ld[0] = '0;
    if (accept)
    begin
      case (i_op_kind)
        OP_STORE:
        begin
          next_s.st_v = 1'b1;
          next_s.st_idx = idx;
          next_s.st_be = be;
          next_s.st_data = i_op_data << {ofs, 3'h0};
        end
        OP_WRITE:
        begin
          next_s.rf[i_op_reg] = i_op_data;
          next_s.deferred_fault_flag[i_op_reg] = 1'b0;
        end
        OP_USE:
        begin
          next_s.use_v = 1'b1;
          next_s.use_data = s.rf[i_op_reg];
          next_s.use_flag = s.deferred_fault_flag[i_op_reg];
        end
        OP_CHK_ADV:
        begin
          next_s.redir = !hit;
        end
        OP_CHK_SPEC:
        begin
          next_s.redir = s.deferred_fault_flag[i_op_reg];
        end
        default:
        begin
          if (is_load)
          begin
            if (i_op_fault && (i_op_kind != OP_SPEC_LOAD))
            begin
              next_s.fault = 1'b1;
            end
            else
            begin
              next_s.ld[0].v = 1'b1;
              next_s.ld[0].rg = i_op_reg;
              next_s.ld[0].data = i_op_fault ? '0 : ld_val;
              next_s.ld[0].flag = i_op_fault;
              next_s.busy[i_op_reg] = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_use_valid = s.use_v;
  assign o_use_data = s.use_data;
  assign o_use_flag = s.use_flag;
  assign o_fault = s.fault;
  assign o_redirect = s.redir;

endmodule // lso_core

//--- hdl/lso_pkg.sv
package lso_pkg;

  // ----------------------------------------------------------------
  // data path geometry
  // ----------------------------------------------------------------
  localparam int DW = 64;
  localparam int NBYTE = 8;
  localparam int OFS_W = 3;
  localparam int SZ_W = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // cycles from load issue to the first cycle a consumer may read
  localparam int LOAD_LAT = 2;
  localparam int LD_STAGES = LOAD_LAT - 1;

  // ----------------------------------------------------------------
  // access size encodings and byte masks
  // ----------------------------------------------------------------
  localparam logic [SZ_W-1:0] SZ_BYTE = 2'h0;
  localparam logic [SZ_W-1:0] SZ_HALF = 2'h1;
  localparam logic [SZ_W-1:0] SZ_WORD = 2'h2;
  localparam logic [NBYTE-1:0] BE_BYTE = 8'h01;
  localparam logic [NBYTE-1:0] BE_HALF = 8'h03;
  localparam logic [NBYTE-1:0] BE_WORD = 8'h0F;
  localparam logic [NBYTE-1:0] BE_QUAD = 8'hFF;

  // ----------------------------------------------------------------
  // operation codes presented by the issue stage
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_LOAD,
    OP_STORE,
    OP_SPEC_LOAD,
    OP_ADV_LOAD,
    OP_CHK_LOAD,
    OP_CHK_ADV,
    OP_CHK_SPEC,
    OP_USE,
    OP_WRITE
  } lso_op_t;

  // byte enables of an aligned access of the given size at the given offset
  function automatic logic [NBYTE-1:0] lso_be(input logic [SZ_W-1:0] sz,
                                               input logic [OFS_W-1:0] ofs);
    logic [NBYTE-1:0] m;
    case (sz)
      SZ_BYTE: m = BE_BYTE;
      SZ_HALF: m = BE_HALF;
      SZ_WORD: m = BE_WORD;
      default: m = BE_QUAD;
    endcase
    return m << ofs;
  endfunction

  function automatic logic [DW-1:0] lso_bits(input logic [NBYTE-1:0] be);
    logic [DW-1:0] b;
    for (int i = 0; i < NBYTE; i++)
    begin
      b[i*8 +: 8] = {8{be[i]}};
    end
    return b;
  endfunction

endpackage

//--- hdl/lso_alt.sv
`timescale 1ns/10ps
module lso_alt import lso_pkg::*; #(
  parameter int NREG = 128,
  parameter int RW = 7,
  parameter int IW = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_alloc,
  input wire logic [RW-1:0] i_alloc_reg,
  input wire logic [IW-1:0] i_alloc_idx,
  input wire logic [NBYTE-1:0] i_alloc_be,
  input wire logic i_alloc_cls,
  input wire logic [SZ_W-1:0] i_alloc_size,
  input wire logic i_inval,
  input wire logic [IW-1:0] i_inval_idx,
  input wire logic [NBYTE-1:0] i_inval_be,
  input wire logic [RW-1:0] i_look_reg,
  input wire logic i_look_cls,
  output logic o_hit
);

  typedef struct packed {
    logic v;
    logic [IW-1:0] idx;
    logic [NBYTE-1:0] be;
    logic cls;
    logic [SZ_W-1:0] size;
  } lso_ent_t;

  typedef struct packed {
    lso_ent_t [NREG-1:0] e;
  } lso_alt_st_t;

  lso_alt_st_t s;
  lso_alt_st_t next_s;
  logic [NREG-1:0] kill;

  // ----------------------------------------------------------------
  // store overlap per entry
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NREG; g++)
  begin : g_kill
    assign kill[g] = s.e[g].v && i_inval && (s.e[g].idx == i_inval_idx)
                     && ((s.e[g].be & i_inval_be) != '0);
  end

  always_comb
  begin
    next_s = s;
    for (int i = 0; i < NREG; i++)
    begin
      if (kill[i])
      begin
        next_s.e[i].v = 1'b0;
      end
    end
    // a new advanced load simply replaces the entry of its register
    if (i_alloc)
    begin
      next_s.e[i_alloc_reg] = '{v: 1'b1, idx: i_alloc_idx, be: i_alloc_be,
                                cls: i_alloc_cls, size: i_alloc_size};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_hit = s.e[i_look_reg].v && (s.e[i_look_reg].cls == i_look_cls);

endmodule // lso_alt

//--- tb/lso_core_asserts.sv
`timescale 1ns/10ps
module lso_core_asserts import lso_pkg::*; #(
  parameter int RW = 7
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_op_valid,
  input wire lso_op_t i_op_kind,
  input wire logic [RW-1:0] i_op_reg,
  input wire logic i_op_fault,
  input wire logic o_op_ready,
  input wire logic o_use_valid,
  input wire logic o_fault,
  input wire logic o_redirect
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic acc;
  logic ld;
  assign acc = i_op_valid && o_op_ready;
  assign ld = i_op_kind inside {OP_LOAD, OP_SPEC_LOAD, OP_ADV_LOAD, OP_CHK_LOAD};
  logic st_req;
  logic ld_flt;
  logic chk_op;
  assign st_req = i_op_valid && i_op_kind == OP_STORE;
  assign ld_flt = acc && i_op_kind == OP_LOAD && i_op_fault;
  assign chk_op = acc && i_op_kind inside {OP_CHK_ADV, OP_CHK_SPEC};
  sequence load_taken;
    acc && i_op_kind == OP_LOAD && !i_op_fault;
  endsequence
  sequence same_reg_next;
    i_op_valid && i_op_kind != OP_STORE && i_op_reg == $past(i_op_reg);
  endsequence
  chk_load_stall: assert property (load_taken ##1 same_reg_next |-> !o_op_ready)
    else $error("consumer taken one cycle after its load");
  chk_ready_idle: assert property (!$past(acc && ld) |-> o_op_ready)
    else $error("stall without a load in flight");
  chk_store_free: assert property (st_req |-> o_op_ready)
    else $error("store held back");
  chk_use_pulse: assert property (acc && i_op_kind == OP_USE |=> o_use_valid)
    else $error("no use result");
  chk_use_cause: assert property (o_use_valid |-> $past(acc && i_op_kind == OP_USE))
    else $error("stray use result");
  chk_spec_defer: assert property (acc && i_op_kind == OP_SPEC_LOAD |=> !o_fault)
    else $error("speculative load raised a fault");
  chk_fault_raise: assert property (ld_flt |=> o_fault)
    else $error("load fault not raised");
  chk_redir_cause: assert property (o_redirect |-> $past(chk_op))
    else $error("redirect without a check");
  chk_reload_quiet: assert property (acc && i_op_kind == OP_CHK_LOAD |=> !o_redirect)
    else $error("check load redirected");
endmodule // lso_core_asserts

//--- tb/lso_mem_model.sv
`timescale 1ns/10ps
module lso_mem_model import lso_pkg::*; #(
  parameter int AW = 11
) (
  input wire logic [AW-1:0] i_addr,
  input wire lso_op_t i_kind,
  output logic o_fault
);
  // --------------------
  // fault map
  // --------------------
  // word 7 faults; advanced loads spared so table effects stay visible
  assign o_fault = i_addr[5:3] == 3'h7 && i_kind != OP_ADV_LOAD;
endmodule // lso_mem_model

//--- tb/test_load_order_and_speculation.sv
`timescale 1ns/10ps
module test_load_order_and_speculation import lso_pkg::*;;
  logic i_clk, i_sys_rst, i_op_valid, i_op_cls, i_op_fault;
  lso_op_t i_op_kind;
  logic [6:0] i_op_reg;
  logic [1:0] i_op_size;
  logic [10:0] i_op_addr;
  logic [63:0] i_op_data, o_use_data, e_dat, v;
  logic o_op_ready, o_use_valid, o_use_flag, o_fault, o_redirect;
  logic [63:0] mem [8], rv [8];
  logic rf [8], tv [8], tc [8];
  logic [2:0] tw [8];
  logic [7:0] tm [8], m;
  logic e_use = 0, e_red = 0, e_flt = 0, e_flg = 0, acc, taken = 1, unk = 0, hit;
  logic [31:0] seed = 32'hA43EA38C;
  int fails = 0, samples_checked = 0, pend = -1, stall = 0, w, o, r;
  lso_core lso_core_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_op_valid(i_op_valid),
    .i_op_kind(i_op_kind), .i_op_reg(i_op_reg), .i_op_cls(i_op_cls), .i_op_size(i_op_size),
    .i_op_addr(i_op_addr), .i_op_data(i_op_data), .i_op_fault(i_op_fault),
    .o_op_ready(o_op_ready), .o_use_valid(o_use_valid), .o_use_data(o_use_data),
    .o_use_flag(o_use_flag), .o_fault(o_fault), .o_redirect(o_redirect));
  lso_mem_model lso_mem_model_inst (.i_addr(i_op_addr), .i_kind(i_op_kind), .o_fault(i_op_fault));
  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp_val(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // --------------------
  // sequential model
  // --------------------
  task automatic apply;
    m = 8'((1 << (1 << i_op_size)) - 1) << i_op_addr[2:0];
    w = i_op_addr[5:3];
    o = i_op_addr[2:0];
    r = i_op_reg[2:0];
    hit = tv[r] && tc[r] == i_op_cls;
    v = 0;
    for (int i = 0; i < 8; i++)
      if (m[i]) v[(i-o)*8 +: 8] = mem[w][i*8 +: 8];
    case (i_op_kind)
      OP_STORE:
      begin
        for (int i = 0; i < 8; i++)
          if (m[i]) mem[w][i*8 +: 8] = i_op_data[(i-o)*8 +: 8];
        for (int j = 0; j < 8; j++)
          if (tv[j] && tw[j] == w && (tm[j] & m) != 0) tv[j] = 0;
      end
      OP_LOAD, OP_SPEC_LOAD, OP_ADV_LOAD, OP_CHK_LOAD:
        if (!(i_op_kind == OP_CHK_LOAD && hit))
        begin
          unk = i_op_fault;
          e_flt = i_op_fault && i_op_kind != OP_SPEC_LOAD;
          if (!e_flt)
          begin
            rv[r] = i_op_fault ? 64'h0 : v;
            rf[r] = i_op_fault;
            pend = r;
          end
          if (i_op_kind == OP_ADV_LOAD)
          begin
            tv[r] = 1;
            tw[r] = w[2:0];
            tm[r] = m;
            tc[r] = i_op_cls;
          end
        end
      OP_CHK_ADV: e_red = !hit;
      OP_CHK_SPEC: e_red = rf[r];
      OP_USE:
      begin
        e_use = 1;
        e_dat = rv[r];
        e_flg = rf[r];
      end
      OP_WRITE:
      begin
        rv[r] = i_op_data;
        rf[r] = 0;
      end
      default: ;
    endcase
  endtask
  initial
  begin
    i_sys_rst = 1'b1;
    {i_op_valid, i_op_cls, i_op_reg, i_op_size, i_op_addr, i_op_data} = '0;
    i_op_kind = OP_USE;
    foreach (mem[i])
    begin
      {mem[i], rv[i], rf[i], tv[i]} = 0;
    end
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 0;
    repeat (4000)
    begin
      @(negedge i_clk);
      cmp_flag(o_use_valid, e_use);
      if (e_use) cmp_val(o_use_data, e_dat);
      if (e_use) cmp_flag(o_use_flag, e_flg);
      cmp_flag(o_redirect, e_red);
      cmp_flag(o_fault, e_flt);
      if (taken)
      begin
        seed = xs(seed);
        r = seed[6:4];
        // every op is its own group
        i_op_valid = 1;
        i_op_kind = lso_op_t'(seed[3:0] % 4'h9);
        i_op_reg = {4'h0, seed[6:4]};
        i_op_cls = seed[7];
        i_op_size = seed[9:8];
        i_op_addr = {5'h0, seed[15:10]} & ~(11'h7 >> (2'h3 - seed[9:8]));
        i_op_data = {seed, xs(seed)};
        if (i_op_kind == OP_ADV_LOAD) i_op_reg[2] = 0;
        if (i_op_kind inside {OP_LOAD, OP_SPEC_LOAD, OP_WRITE}) i_op_reg[2] = 1;
        if (i_op_kind == OP_CHK_LOAD && !(tv[r] && tc[r] == seed[7])) i_op_reg[2] = 1;
      end
      #1;
      if (!unk) cmp_flag(o_op_ready, !(pend == i_op_reg && i_op_kind != OP_STORE));
      acc = o_op_ready;
      stall = acc ? 0 : stall + 1;
      if (stall > 3)
      begin
        fails++;
        break;
      end
      @(posedge i_clk);
      taken = acc;
      {e_use, e_red, e_flt, unk} = 0;
      pend = -1;
      if (acc) apply;
      r = seed[6:4];
    end
    give_verdict;
  end
endmodule // test_load_order_and_speculation
bind lso_core lso_core_asserts #(.RW(RW)) lso_core_asserts_inst (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_op_valid(i_op_valid), .i_op_kind(i_op_kind), .i_op_reg(i_op_reg),
  .i_op_fault(i_op_fault), .o_op_ready(o_op_ready), .o_use_valid(o_use_valid),
  .o_fault(o_fault), .o_redirect(o_redirect));
